/* File: logic/adc_clk_div.sv */
// Operation-clock enable divider: /4, /2 or every source cycle
`timescale 1ns/100ps
`default_nettype none
module adc_clk_div
    import adc_seq_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic [1:0] div_sel_in,
    output logic tick_out
);
    // ==========================================
    // State
    typedef struct packed {
        logic [1:0] cnt;    // Free divider count
    } div_state_s;
    div_state_s st_r;
    div_state_s st_nxt;

    // Next count; restarts while idle so each conversion is phase-aligned
    always_comb begin
        st_nxt = st_r;
        if (!run_in) begin
            st_nxt.cnt = 2'h0;
        end else begin
            st_nxt.cnt = st_r.cnt + 2'h1;
        end
    end

    // Register
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Enable pulse per selected ratio
    always_comb begin
        unique case (div_sel_in)
            DIV_BY4: tick_out = run_in && (st_r.cnt == 2'h3);
            DIV_BY2: tick_out = run_in && st_r.cnt[0];
            default: tick_out = run_in;
        endcase
    end

    // Assertion: divided-by-four enable never on two adjacent cycles
    chk_div_spacing: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (tick_out && div_sel_in == DIV_BY4 && $stable(div_sel_in)) |=> !tick_out)
        else $error("divide-by-four enable too dense");
endmodule : adc_clk_div
`default_nettype wire

/* File: logic/adc_seq.sv */
// Successive-approximation converter sequencer for one-shot and repeat modes
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Hold on: sample three operation cycles first.
// - Hold on: convert captured voltage, not live.
// - 8 or 10 bit; 8 resolves top bits.
// - Alternate group moves channels 0-4 pins.
// - Operation clock is source /4, /2, /1.
// - One-shot start converts one channel once.
// - One-shot end: store, request, clear, halt.
// - Repeat stores every result, no request.
// - Repeat runs until start flag cleared.
// - Hold on: 33 or 28 cycles.
// - Hold off: 59 or 49 cycles.
// - Undivided source equals core clock.
module adc_seq
    import adc_seq_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire adc_cfg_s cfg_in,
    input wire logic start_set_in,
    input wire logic start_clr_in,
    input wire logic cmp_high_in,
    output logic start_flag_out,
    output logic busy_out,
    output logic irq_req_out,
    output afe_req_s afe_out,
    output logic [9:0] result_out [NUM_CH]
);
    // ==========================================
    // Reset synchroniser
    logic rst_meta_r;
    logic rst_sync_r;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ==========================================
    // State
    typedef struct packed {
        seq_state_e fsm;          // Sequencer state
        logic start;              // Conversion start flag
        logic irq;                // Conversion request (sticky)
        logic [5:0] cyc;          // Operation cycles used in this conversion
        logic [3:0] bit_idx;      // Approximation step number
        logic [9:0] sar;          // Successive approximation register
        logic [9:0] trial;        // Current trial code
        logic [2:0] ch;           // Channel latched at conversion start
        logic res8;               // Resolution latched at conversion start
        logic hold;               // Hold option latched at conversion start
        logic rpt;                // Repeat mode latched at conversion start
        logic alt;                // Group select latched at conversion start
        logic [NUM_CH-1:0][9:0] res; // Per-channel result registers
    } seq_state_s;
    seq_state_s st_r;
    seq_state_s st_nxt;
    logic tick;                   // Operation-clock enable
    logic [5:0] total;            // Cycles for the current conversion
    logic [5:0] pre;              // Cycles before approximation starts
    logic [3:0] nbits;            // Steps for current resolution
    logic run;                    // Divider runs while converting

    assign run = (st_r.fsm != ST_IDLE);

    // undivided: enable equals core clock; divider select
    adc_clk_div u_div (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_sync_r),
        .run_in(run),
        .div_sel_in(cfg_in.div_sel),
        .tick_out(tick)
    );

    // conversion length by mode and resolution
    always_comb begin
        unique case ({st_r.hold, st_r.res8})
            2'b11: total = CYC_HOLD_8;
            2'b10: total = CYC_HOLD_10;
            2'b01: total = CYC_LIVE_8;
            default: total = CYC_LIVE_10;
        endcase
        nbits = st_r.res8 ? BITS_8 : BITS_10;
        pre = total - {2'h0, nbits};
    end

    // ==========================================
    // Step and completion decode
    localparam logic [9:0] TRIAL_MSB = 10'h200;  // First trial code, top bit only
    localparam seq_state_s SEQ_RST = '{fsm: ST_IDLE, default: '0}; // State after reset
    logic step;                   // Tick inside the approximation window
    logic last;                   // Tick that resolves the final bit
    logic [9:0] sar_try;          // Approximation after this step's decision

    // one bit decided per step, top bit first
    always_comb begin
        step = tick && (st_r.fsm == ST_CONV) && (st_r.cyc >= pre);
        last = step && (st_r.bit_idx == (nbits - 4'h1));
        // Keep the trial bit when the input is at or above the trial code
        sar_try = cmp_high_in ? st_r.trial : st_r.sar;
    end

    // ==========================================
    // Sequencer next-state
    always_comb begin
        st_nxt = st_r;
        // Software start flag; a same-cycle set wins over a clear
        if (start_clr_in) begin
            st_nxt.start = 1'b0;
        end
        if (start_set_in) begin
            st_nxt.start = 1'b1;
            // A new start withdraws the previous completion request
            st_nxt.irq = 1'b0;
        end
        unique case (st_r.fsm)
            ST_IDLE: begin
                // start latches settings, begins a conversion
                if (st_r.start) begin
                    st_nxt.ch = cfg_in.channel;
                    st_nxt.res8 = cfg_in.res_8bit;
                    st_nxt.hold = cfg_in.hold_en;
                    st_nxt.rpt = cfg_in.repeat_mode;
                    st_nxt.alt = cfg_in.alt_group;
                    st_nxt.cyc = 6'h00;
                    st_nxt.bit_idx = 4'h0;
                    st_nxt.sar = 10'h000;
                    st_nxt.trial = TRIAL_MSB;
                    // hold option opens with the sampling window
                    st_nxt.fsm = cfg_in.hold_en ? ST_SAMPLE : ST_CONV;
                end
            end
            ST_SAMPLE: begin
                // cleared flag stops at once, no result
                if (!st_r.start) begin
                    st_nxt.fsm = ST_IDLE;
                end else if (tick) begin
                    st_nxt.cyc = st_r.cyc + 6'h01;
                    if (st_r.cyc == (CYC_SAMPLE - 6'h01)) begin
                        st_nxt.fsm = ST_CONV;
                    end
                end
            end
            ST_CONV: begin
                // cleared flag stops at once, no result
                if (!st_r.start) begin
                    st_nxt.fsm = ST_IDLE;
                end else if (tick) begin
                    st_nxt.cyc = st_r.cyc + 6'h01;
                    if (step) begin
                        st_nxt.sar = sar_try;
                        st_nxt.bit_idx = st_r.bit_idx + 4'h1;
                        st_nxt.trial = sar_try | (TRIAL_MSB >> (st_r.bit_idx + 4'h1));
                    end
                    if (last) begin
                        // 8-bit result right-aligned, top bits zero
                        st_nxt.res[st_r.ch] = st_r.res8 ? {2'h0, sar_try[9:2]} : sar_try;
                        if (st_r.rpt) begin
                            st_nxt.cyc = 6'h00;
                            st_nxt.bit_idx = 4'h0;
                            st_nxt.sar = 10'h000;
                            st_nxt.trial = TRIAL_MSB;
                            st_nxt.fsm = st_r.hold ? ST_SAMPLE : ST_CONV;
                        end else begin
                            st_nxt.irq = 1'b1;
                            st_nxt.start = 1'b0;
                            st_nxt.fsm = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                // Illegal one-hot code falls back to idle
                st_nxt.fsm = ST_IDLE;
            end
        endcase
    end

    // State register, cleared by the synchronised reset
    always_ff @(posedge core_clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            st_r <= SEQ_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign start_flag_out = st_r.start;
    assign busy_out = run;
    assign irq_req_out = st_r.irq;

    // Result registers straight from the state flops
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            result_out[i] = st_r.res[i];
        end
    end

    // Front-end requests decoded from the state flops
    always_comb begin
        afe_out = '0;
        // sampling switch closed in the window
        afe_out.sample = (st_r.fsm == ST_SAMPLE);
        // capacitor isolated while converting held voltage
        afe_out.hold = st_r.hold && (st_r.fsm == ST_CONV);
        afe_out.trial = st_r.trial;
        if (run) begin
            // alternate group takes channels zero to four
            if (st_r.alt && (int'(st_r.ch) < ALT_CH)) begin
                afe_out.mux_alt[st_r.ch] = 1'b1;
            end else begin
                afe_out.mux_dflt[st_r.ch] = 1'b1;
            end
        end
    end

    // ==========================================
    // Assertions
    chk_sample_window: assert property (@(posedge core_clk_in) disable iff (!rst_sync_r)
        (st_r.fsm == ST_SAMPLE) |-> (st_r.cyc < CYC_SAMPLE))
        else $error("sampling window too long");
    chk_hold_isolates: assert property (@(posedge core_clk_in) disable iff (!rst_sync_r)
        (st_r.fsm == ST_CONV && st_r.hold) |-> (afe_out.hold && !afe_out.sample))
        else $error("held voltage not isolated");
    chk_mux_onehot: assert property (@(posedge core_clk_in) disable iff (!rst_sync_r)
        busy_out |-> $onehot({afe_out.mux_dflt, afe_out.mux_alt}))
        else $error("input select not one-hot");
    chk_oneshot_halt: assert property (@(posedge core_clk_in) disable iff (!rst_sync_r)
        (last && st_r.start && !st_r.rpt) |=> (irq_req_out && !start_flag_out && !busy_out))
        else $error("one-shot end not handled");
    chk_repeat_no_req: assert property (@(posedge core_clk_in) disable iff (!rst_sync_r)
        (last && st_r.start && st_r.rpt) |=> (!irq_req_out && busy_out))
        else $error("repeat end raised request or stopped");
    chk_conv_length: assert property (@(posedge core_clk_in) disable iff (!rst_sync_r)
        (st_r.fsm == ST_CONV) |-> (st_r.cyc < total))
        else $error("conversion ran past its length");
    chk_result_frozen: assert property (@(posedge core_clk_in) disable iff (!rst_sync_r)
        !(last && st_r.start) |=> $stable(st_r.res))
        else $error("result changed outside completion");

    // Cover the main scenarios
    cov_oneshot_done: cover property (@(posedge core_clk_in) $rose(irq_req_out));
    cov_repeat_again: cover property (@(posedge core_clk_in) (last && st_r.start && st_r.rpt));
    cov_hold_sample: cover property (@(posedge core_clk_in) $rose(afe_out.sample));
    cov_alt_group: cover property (@(posedge core_clk_in) (busy_out && |afe_out.mux_alt));
endmodule : adc_seq
`default_nettype wire

/* File: logic/adc_seq_pkg.sv */
// Package: constants, enums and structs shared by the converter sequencer
package adc_seq_pkg;
    // ==========================================
    // Conversion cycle counts in operation-clock cycles
    localparam logic [5:0] CYC_HOLD_10 = 6'h21;   // 33 cycles, hold on, 10 bit
    localparam logic [5:0] CYC_HOLD_8 = 6'h1C;    // 28 cycles, hold on, 8 bit
    localparam logic [5:0] CYC_LIVE_10 = 6'h3B;   // 59 cycles, hold off, 10 bit
    localparam logic [5:0] CYC_LIVE_8 = 6'h31;    // 49 cycles, hold off, 8 bit
    localparam logic [5:0] CYC_SAMPLE = 6'h03;    // Sampling window with hold on
    localparam logic [3:0] BITS_10 = 4'hA;        // Approximation steps, 10 bit
    localparam logic [3:0] BITS_8 = 4'h8;         // Approximation steps, 8 bit
    // ==========================================
    // Divider selection codes and reset values
    localparam logic [1:0] DIV_BY4 = 2'h0;        // Source clock divided by four
    localparam logic [1:0] DIV_BY2 = 2'h1;        // Source clock divided by two
    localparam logic [1:0] DIV_BY1 = 2'h2;        // Undivided (3 also undivided)
    localparam logic [9:0] RESULT_RST = 10'h000;  // Result register reset value
    localparam int NUM_CH = 8;                    // Channels zero to seven
    localparam int ALT_CH = 5;                    // Channels with an alternate pin
    // ==========================================
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV = 3'b100
    } seq_state_e;
    // Software configuration bundle
    typedef struct packed {
        logic repeat_mode;     // 0 one-shot, 1 repeat
        logic hold_en;         // Sample-and-hold option
        logic res_8bit;        // 1 selects 8-bit resolution
        logic alt_group;       // 1 routes channels 0..4 to alternate group
        logic [1:0] div_sel;   // Operation clock divider select
        logic [2:0] channel;   // Selected channel
    } adc_cfg_s;
    // Analog front end request bundle
    typedef struct packed {
        logic sample;          // Sampling switch closed
        logic hold;            // Hold capacitor isolated from input
        logic [9:0] trial;     // Trial code driven to the comparator DAC
        logic [7:0] mux_dflt;  // One-hot select, default input group
        logic [4:0] mux_alt;   // One-hot select, alternate input group
    } afe_req_s;
endpackage : adc_seq_pkg

/* File: verification/afe_model.sv */
// Analog front end model: channel level, hold capacitor and comparator
`timescale 1ns/100ps
`default_nettype none
module afe_model
    import adc_seq_pkg::*;
(
    input wire logic core_clk_in,
    input wire afe_req_s afe_in,
    input wire logic [9:0] level_in,
    output logic cmp_high_out
);
    // reference stays connected well before any start
    // every analog pin here acts as an input only
    logic [9:0] held_r; // Voltage kept on the hold capacitor
    always @(posedge core_clk_in) begin
        if (afe_in.sample) begin
            held_r <= level_in;
        end
    end
    // Comparator high when input is at or above the trial code
    assign cmp_high_out = ((afe_in.hold ? held_r : level_in) >= afe_in.trial);
endmodule : afe_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench: one-shot and repeat conversions
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import adc_seq_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    adc_cfg_s cfg = '0;
    logic set_r = 1'b0;
    logic clr_r = 1'b0;
    logic [9:0] level = 10'h000;
    logic cmp, flag, busy, irq;
    afe_req_s afe;
    logic [9:0] res [NUM_CH];
    int fails = 0;
    int checks = 0;
    int n;
    // Clock at 20 MHz
    always #25 core_clk_in = ~core_clk_in;
    adc_seq u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg),
        .start_set_in(set_r), .start_clr_in(clr_r), .cmp_high_in(cmp),
        .start_flag_out(flag), .busy_out(busy), .irq_req_out(irq), .afe_out(afe),
        .result_out(res));
    afe_model u_afe (.core_clk_in(core_clk_in), .afe_in(afe), .level_in(level),
        .cmp_high_out(cmp));
    // Verdict and end of run
    task automatic complete_run;
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // Compare one value
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Start pulse, then count busy cycles to completion
    task automatic run_one(input adc_cfg_s c, input logic [9:0] lv);
        logic seen;
        cfg <= c;
        level <= lv;
        set_r <= 1'b1;
        @(posedge core_clk_in);
        set_r <= 1'b0;
        seen = 1'b0;
        n = 0;
        do begin
            @(posedge core_clk_in);
            #1;
            n++;
            if (irq === 1'b1) seen = 1'b1;
            if (n > 300) begin
                fails++;
                complete_run();
            end
        end while (busy !== 1'b0);
        chk({9'h000, seen}, 10'h001, "irq");
        chk({9'h000, flag}, 10'h000, "flag");
        chk(res[c.channel], c.res_8bit ? {2'h0, lv[9:2]} : lv, "result");
    endtask : run_one
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        chk(res[0], RESULT_RST, "reset");
        // hold runs only at 10 MHz or 20 MHz operation clock; the sequencer does not check this and also runs hold at /4
        // Hold on, 10 bit, undivided
        run_one('{1'b0, 1'b1, 1'b0, 1'b0, DIV_BY1, 3'h7}, 10'h2A5);
        chk((n >= 33 && n <= 35) ? 10'h001 : 10'h000, 10'h001, "hold10");
        // Hold on, 8 bit, alternate group, by two
        run_one('{1'b0, 1'b1, 1'b1, 1'b1, DIV_BY2, 3'h4}, 10'h3FF);
        chk((n >= 56 && n <= 59) ? 10'h001 : 10'h000, 10'h001, "hold8");
        // Hold off, 8 bit, by four
        run_one('{1'b0, 1'b0, 1'b1, 1'b0, DIV_BY4, 3'h0}, 10'h0C7);
        chk((n >= 196 && n <= 200) ? 10'h001 : 10'h000, 10'h001, "live8");
        chk(res[7], 10'h2A5, "kept");
        // Repeat mode: results follow the level, no request
        cfg <= '{1'b1, 1'b0, 1'b0, 1'b1, DIV_BY1, 3'h2};
        level <= 10'h155;
        set_r <= 1'b1;
        @(posedge core_clk_in);
        set_r <= 1'b0;
        repeat (130) @(posedge core_clk_in);
        #1;
        chk(res[2], 10'h155, "rep1");
        chk({8'h00, afe.mux_alt[2], afe.mux_dflt[2]}, 10'h002, "mux");
        level <= 10'h0AA;
        repeat (130) @(posedge core_clk_in);
        #1;
        chk(res[2], 10'h0AA, "rep2");
        chk({8'h00, flag, irq}, 10'h002, "noirq");
        clr_r <= 1'b1;
        @(posedge core_clk_in);
        clr_r <= 1'b0;
        repeat (70) @(posedge core_clk_in);
        chk({8'h00, flag, busy}, 10'h000, "stop");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
